/* File: sim/sra_host_model.sv */
// Host controller model that reaches the status registers.
module sra_host_model (
   // Clock
   input wire logic                      clk,
   // Requests
   output logic                          reg_rd,
   output logic                          reg_wr,
   output logic [3:0]                    reg_sel,
   output logic [sra_pkg::REG_W-1:0]     reg_wdata,
   output logic                          clear_status,
   // Answers
   input wire logic [sra_pkg::REG_W-1:0] reg_rdata,
   input wire logic                      error_queue_clear
);
   timeunit 1ns;
   timeprecision 1ns;
   import sra_pkg::*;
   initial begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_sel = 4'h0;
      reg_wdata = 16'h0000;
      clear_status = 1'b0;
   end
   // Released write data is inverted so a stale value is never mistaken for a live one.
   task automatic wr(input logic [3:0] s, input logic [15:0] v);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_sel = s;
      reg_wdata = v;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~v;
   endtask
   task automatic rd(input logic [3:0] s, output logic [15:0] v);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_sel = s;
      @(negedge clk);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask
   task automatic clr(output logic eq);
      @(negedge clk);
      clear_status = 1'b1;
      @(negedge clk);
      clear_status = 1'b0;
      eq = error_queue_clear;
   endtask
   task automatic init();
      logic eq;
      clr(eq);
      wr(SEL_SRE, 16'h0000);
      wr(SEL_SE_ENAB, 16'h0000);
   endtask
endmodule

/* File: sim/sra_properties.sv */
// Port-level checker for the status reporting aggregator, bound to its top.
module sra_checker (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      rstn,
   // Sources
   input wire logic                      calibrating,
   input wire logic                      measuring,
   input wire logic [1:0]                ref_source,
   input wire logic                      ref_locked,
   input wire logic                      cmd_error,
   input wire logic                      power_on,
   // Register access
   input wire logic                      reg_rd,
   input wire logic                      reg_wr,
   input wire logic [3:0]                reg_sel,
   input wire logic [sra_pkg::REG_W-1:0] reg_wdata,
   input wire logic                      clear_status,
   // Answers
   input wire logic [sra_pkg::REG_W-1:0] reg_rdata,
   input wire logic                      error_queue_clear,
   input wire logic [7:0]                status_byte,
   input wire logic                      srq
);
   timeunit 1ns;
   timeprecision 1ns;
   import sra_pkg::*;
   // Shadow enables; cleared on power-on too, which can only silence a check, never fake one.
   logic [7:0] ese_q, sre_q, que_q;
   always_ff @(posedge clk) begin
      if (!rstn || power_on) begin
         ese_q <= 8'h00;
         sre_q <= 8'h00;
         que_q <= 8'h00;
      end else if (reg_wr) begin
         case (reg_sel)
            SEL_SE_ENAB: ese_q <= reg_wdata[7:0];
            SEL_SRE:     sre_q <= reg_wdata[7:0];
            SEL_QU_ENAB: que_q <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_q15_zero; !reg_rdata[15]; endproperty
   a_q15_zero: assert property (p_q15_zero) else $error("read data bit 15 set");
   property p_eq_clear; error_queue_clear == $past(clear_status); endproperty
   a_eq_clear: assert property (p_eq_clear) else $error("error queue clear out of step");
   property p_rqs_srq; srq == status_byte[6]; endproperty
   a_rqs_srq: assert property (p_rqs_srq) else $error("request bit and srq differ");
   property p_cme_path; cmd_error && ese_q[5] && sre_q[5] |-> ##2 status_byte[5] && srq; endproperty
   a_cme_path: assert property (p_cme_path) else $error("command error not routed to srq");
   property p_lock_path;
      $rose(ref_locked) && (ref_source == REF_FRONT || ref_source == REF_BACKPLANE) && que_q[6] && sre_q[3]
         |-> ##[1:4] status_byte[3] && srq;
   endproperty
   a_lock_path: assert property (p_lock_path) else $error("lock not routed to srq");
   property p_sre_rb;
      reg_wr && reg_sel == SEL_SRE ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_sel == SEL_SRE
         |=> reg_rdata == ($past(reg_wdata, 3) & 16'h00bf);
   endproperty
   a_sre_rb: assert property (p_sre_rb) else $error("request enable readback wrong");
   property p_op_cond;
      reg_rd && reg_sel == SEL_OP_COND && $stable(calibrating) && $stable(measuring) && $stable(ref_source)
         |=> reg_rdata == {6'h00, $past(ref_source) == REF_INTERNAL, 4'h0, $past(measuring), 3'h0,
                           $past(calibrating)};
   endproperty
   a_op_cond: assert property (p_op_cond) else $error("operation condition wrong");
   property p_qu_mask;
      reg_rd && (reg_sel == SEL_QU_EVENT || reg_sel == SEL_QU_ENAB) |=> (reg_rdata & ~QU_USED_MASK) == 16'h0000;
   endproperty
   a_qu_mask: assert property (p_qu_mask) else $error("unused questionable bit set");
   c_cme: cover property (cmd_error ##2 srq);
   c_lock: cover property ($rose(ref_locked) ##[1:4] status_byte[3]);
   c_clear: cover property (clear_status ##1 error_queue_clear);
   c_oper: cover property ($rose(status_byte[7]));
endmodule
bind sra_top sra_checker u_chk (
   .clk(clk), .rstn(rstn), .calibrating(calibrating), .measuring(measuring), .ref_source(ref_source),
   .ref_locked(ref_locked), .cmd_error(cmd_error), .power_on(power_on), .reg_rd(reg_rd), .reg_wr(reg_wr),
   .reg_sel(reg_sel), .reg_wdata(reg_wdata), .clear_status(clear_status), .reg_rdata(reg_rdata),
   .error_queue_clear(error_queue_clear), .status_byte(status_byte), .srq(srq)
);

/* File: sim/status_reporting_aggregator_tb_top.sv */
// Self-checking bench for the status reporting aggregator.
module status_reporting_aggregator_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sra_pkg::*;
   localparam int QB[5] = '{8, 9, 10, 11, 14};
   localparam int SB[6] = '{5, 2, 3, 4, 0, 7};
   logic             clk, rstn, calibrating, measuring, ref_locked, avail, eq;
   logic             reg_rd, reg_wr, clear_status, error_queue_clear, srq;
   logic [1:0]       ref_source;
   logic [4:0]       qs;
   logic [5:0]       ss;
   logic [3:0]       reg_sel;
   logic [REG_W-1:0] reg_wdata, reg_rdata, d;
   logic [7:0]       status_byte;
   int               bad_count, check_count;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   sra_top u_dut (
      .clk(clk), .rstn(rstn), .calibrating(calibrating), .measuring(measuring), .ref_source(ref_source),
      .ref_locked(ref_locked), .output_available(avail), .cal_failed(qs[0]), .rate_over_limit(qs[1]),
      .start_index_over(qs[2]), .size_over(qs[3]), .param_ignored(qs[4]), .cmd_error(ss[0]),
      .query_error(ss[1]), .device_error(ss[2]), .exec_error(ss[3]), .op_complete(ss[4]), .power_on(ss[5]),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .clear_status(clear_status),
      .reg_rdata(reg_rdata), .error_queue_clear(error_queue_clear), .status_byte(status_byte), .srq(srq)
   );
   sra_host_model u_host (
      .clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
      .clear_status(clear_status), .reg_rdata(reg_rdata), .error_queue_clear(error_queue_clear)
   );
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wait_srq();
      for (int n = 0; n < 8 && srq !== 1'b1; n++) @(negedge clk);
      if (srq !== 1'b1) begin
         chk("srq wait", {15'h0, srq}, 16'h0001);
         tally_and_finish();
      end
   endtask
   task automatic settle(input logic c, input logic m, input logic [1:0] r);
      calibrating = c;
      measuring = m;
      ref_source = r;
      repeat (3) @(negedge clk);
      u_host.rd(SEL_OP_COND, d);
   endtask
   task automatic t_reset();
      logic [3:0] sels[4] = '{SEL_OP_ENAB, SEL_QU_ENAB, SEL_SE_ENAB, SEL_SRE};
      foreach (sels[i]) begin
         u_host.rd(sels[i], d);
         chk("enable", d, 16'h0000);
      end
      $display("Test reset done");
   endtask
   task automatic t_cond();
      settle(1'b1, 1'b0, REF_INTERNAL);
      chk("op cal", d, 16'h0201);
      settle(1'b0, 1'b1, REF_FRONT);
      chk("op meas", d, 16'h0010);
      u_host.wr(SEL_OP_COND, 16'hffff);
      u_host.rd(SEL_OP_COND, d);
      chk("op reread", d, 16'h0010);
      settle(1'b0, 1'b0, REF_BACKPLANE);
      chk("op backplane", d, 16'h0000);
      u_host.rd(SEL_OP_EVENT, d);
      chk("op sticky", d & 16'h0011, 16'h0011);
      u_host.rd(SEL_OP_EVENT, d);
      chk("op cleared", d & 16'h0011, 16'h0000);
      u_host.wr(SEL_OP_ENAB, 16'hffff);
      u_host.rd(SEL_OP_ENAB, d);
      chk("op enable", d, 16'h0211);
      u_host.wr(SEL_OP_ENAB, 16'h0010);
      settle(1'b0, 1'b1, REF_BACKPLANE);
      u_host.rd(SEL_STB, d);
      chk("stb oper", d, 16'h0080);
      u_host.wr(SEL_OP_ENAB, 16'h0000);
      $display("Test condition done");
   endtask
   task automatic t_events();
      foreach (QB[i]) begin
         @(negedge clk) qs[i] = 1'b1;
         @(negedge clk) qs[i] = 1'b0;
         u_host.rd(SEL_QU_EVENT, d);
         chk("ques event", d, 16'h0001 << QB[i]);
      end
      foreach (SB[i]) begin
         @(negedge clk) ss[i] = 1'b1;
         @(negedge clk) ss[i] = 1'b0;
         u_host.rd(SEL_SE_EVENT, d);
         chk("std event", d, 16'h0001 << SB[i]);
      end
      @(negedge clk) qs[0] = 1'b1;
      ss[0] = 1'b1;
      @(negedge clk) qs[0] = 1'b0;
      ss[0] = 1'b0;
      u_host.clr(eq);
      chk("queue clear", {15'h0, eq}, 16'h0001);
      u_host.rd(SEL_QU_EVENT, d);
      chk("ques cleared", d, 16'h0000);
      u_host.rd(SEL_SE_EVENT, d);
      chk("std cleared", d, 16'h0000);
      $display("Test events done");
   endtask
   task automatic t_cme();
      u_host.init();
      u_host.wr(SEL_SE_ENAB, 16'h0020);
      u_host.wr(SEL_SRE, 16'h0020);
      u_host.rd(SEL_SRE, d);
      chk("sre", d, 16'h0020);
      @(negedge clk) ss[0] = 1'b1;
      @(negedge clk) ss[0] = 1'b0;
      wait_srq();
      chk("stb cme", {8'h00, status_byte}, 16'h0060);
      u_host.rd(SEL_STB, d);
      chk("poll", d, 16'h0060);
      u_host.rd(SEL_SE_EVENT, d);
      repeat (3) @(negedge clk);
      chk("stb idle", {7'h00, srq, status_byte}, 16'h0000);
      $display("Test command error done");
   endtask
   task automatic t_lock();
      u_host.wr(SEL_QU_ENAB, 16'hffff);
      u_host.rd(SEL_QU_ENAB, d);
      chk("ques enable", d, 16'h4f40);
      u_host.wr(SEL_QU_ENAB, 16'h0040);
      u_host.wr(SEL_SRE, 16'h0008);
      ref_locked = 1'b1;
      wait_srq();
      chk("stb lock", {8'h00, status_byte}, 16'h0048);
      u_host.rd(SEL_QU_EVENT, d);
      chk("lock back", d, 16'h0040);
      settle(1'b0, 1'b0, REF_FRONT);
      ref_locked = 1'b0;
      repeat (2) @(negedge clk);
      ref_locked = 1'b1;
      repeat (3) @(negedge clk);
      u_host.rd(SEL_QU_EVENT, d);
      chk("lock front", d, 16'h0040);
      avail = 1'b1;
      repeat (2) @(negedge clk);
      u_host.rd(SEL_STB, d);
      chk("stb avail", d, 16'h0010);
      avail = 1'b0;
      $display("Test lock done");
   endtask
   initial begin
      rstn = 1'b0;
      {calibrating, measuring, ref_locked, avail, qs, ss} = '0;
      ref_source = REF_INTERNAL;
      bad_count = 0;
      check_count = 0;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      t_reset();
      t_cond();
      t_events();
      t_cme();
      t_lock();
      tally_and_finish();
   end
endmodule

/* File: verilog/sra_event_group.sv */
// One status group: condition, sticky event and enable registers with summary.
module sra_event_group #(
   parameter int unsigned                W         = 16,
   parameter logic [W-1:0]               USED_MASK = '1
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rstn,
   // Status sources
   input  wire logic [W-1:0]  cond_in,
   input  wire logic [W-1:0]  event_set,
   // Register access
   input  wire logic          event_read,
   input  wire logic          clear_all,
   input  wire logic          enable_we,
   input  wire logic [W-1:0]  enable_wdata,
   // Results
   output logic      [W-1:0]  cond_out,
   output logic      [W-1:0]  event_q,
   output logic      [W-1:0]  enable_q,
   output logic               summary
);
   logic [W-1:0] cond_q;

   // Condition follows the live status; reads have no side effect.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cond_q <= '0;
      end else begin
         cond_q <= cond_in & USED_MASK;
      end
   end
   assign cond_out = cond_q;

   // A new event in the cycle of a read or clear still lands, so none is lost.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         event_q <= '0;
      end else if (event_read || clear_all) begin
         event_q <= event_set & USED_MASK;
      end else begin
         event_q <= (event_q | event_set) & USED_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         enable_q <= '0;
      end else if (enable_we) begin
         enable_q <= enable_wdata & USED_MASK;
      end
   end

   assign summary = |(event_q & enable_q);
endmodule

/* File: verilog/sra_pkg.sv */
// Package of constants for the status reporting aggregator.
package sra_pkg;
   localparam int unsigned REG_W         = 16;
   localparam int unsigned ESR_W         = 8;
   // Operation group bit positions.
   localparam int unsigned OP_CAL_BIT    = 0;
   localparam int unsigned OP_MEAS_BIT   = 4;
   localparam int unsigned OP_INTREF_BIT = 9;
   localparam logic [15:0] OP_USED_MASK  = 16'h0211;
   // Questionable group bit positions.
   localparam int unsigned QU_LOCK_BIT   = 6;
   localparam int unsigned QU_CALERR_BIT = 8;
   localparam int unsigned QU_MISS_BIT   = 9;
   localparam int unsigned QU_START_BIT  = 10;
   localparam int unsigned QU_SIZE_BIT   = 11;
   localparam int unsigned QU_WARN_BIT   = 14;
   localparam logic [15:0] QU_USED_MASK  = 16'h4f40;
   // Standard event register bits.
   localparam int unsigned SE_OPC_BIT    = 0;
   localparam int unsigned SE_QYE_BIT    = 2;
   localparam int unsigned SE_DDE_BIT    = 3;
   localparam int unsigned SE_EXE_BIT    = 4;
   localparam int unsigned SE_CME_BIT    = 5;
   localparam int unsigned SE_PON_BIT    = 7;
   localparam logic [7:0]  SE_USED_MASK  = 8'hbd;
   // Status byte bit positions.
   localparam int unsigned SB_QUES_BIT   = 3;
   localparam int unsigned SB_MAV_BIT    = 4;
   localparam int unsigned SB_ESB_BIT    = 5;
   localparam int unsigned SB_RQS_BIT    = 6;
   localparam int unsigned SB_OPER_BIT   = 7;
   localparam logic [7:0]  SRE_USED_MASK = 8'hbf;
   // Reference source selection codes.
   localparam logic [1:0]  REF_INTERNAL  = 2'h0;
   localparam logic [1:0]  REF_FRONT     = 2'h1;
   localparam logic [1:0]  REF_BACKPLANE = 2'h2;
   // Register selector codes for reads and writes.
   localparam logic [3:0]  SEL_OP_COND   = 4'h0;
   localparam logic [3:0]  SEL_OP_EVENT  = 4'h1;
   localparam logic [3:0]  SEL_OP_ENAB   = 4'h2;
   localparam logic [3:0]  SEL_QU_COND   = 4'h3;
   localparam logic [3:0]  SEL_QU_EVENT  = 4'h4;
   localparam logic [3:0]  SEL_QU_ENAB   = 4'h5;
   localparam logic [3:0]  SEL_SE_EVENT  = 4'h6;
   localparam logic [3:0]  SEL_SE_ENAB   = 4'h7;
   localparam logic [3:0]  SEL_SRE       = 4'h8;
   localparam logic [3:0]  SEL_STB       = 4'h9;
   // Service request line states.
   typedef enum logic [1:0] {
      SRA_SRQ_IDLE = 2'b01,
      SRA_SRQ_ASSERT = 2'b10
   } sra_srq_state_t;
endpackage

/* File: verilog/sra_top.sv */
// Status reporting aggregator for the interval_analyzer status model.
module sra_top (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rstn,
   // Live instrument status
   input  wire logic                        calibrating,
   input  wire logic                        measuring,
   input  wire logic [1:0]                  ref_source,
   input  wire logic                        ref_locked,
   input  wire logic                        output_available,
   // One-cycle event strobes
   input  wire logic                        cal_failed,
   input  wire logic                        rate_over_limit,
   input  wire logic                        start_index_over,
   input  wire logic                        size_over,
   input  wire logic                        param_ignored,
   input  wire logic                        cmd_error,
   input  wire logic                        query_error,
   input  wire logic                        device_error,
   input  wire logic                        exec_error,
   input  wire logic                        op_complete,
   input  wire logic                        power_on,
   // Register access port
   input  wire logic                        reg_rd,
   input  wire logic                        reg_wr,
   input  wire logic [3:0]                  reg_sel,
   input  wire logic [sra_pkg::REG_W-1:0]   reg_wdata,
   input  wire logic                        clear_status,
   // Answers
   output logic      [sra_pkg::REG_W-1:0]   reg_rdata,
   output logic                             error_queue_clear,
   output logic      [7:0]                  status_byte,
   output logic                             srq
);
   import sra_pkg::*;

   logic [REG_W-1:0] op_cond_in;
   logic [REG_W-1:0] op_cond;
   logic [REG_W-1:0] op_event;
   logic [REG_W-1:0] op_enab;
   logic             op_summary;
   logic [REG_W-1:0] qu_set;
   logic [REG_W-1:0] qu_cond;
   logic [REG_W-1:0] qu_event;
   logic [REG_W-1:0] qu_enab;
   logic             qu_summary;
   logic [ESR_W-1:0] se_set;
   logic [ESR_W-1:0] se_event;
   logic [ESR_W-1:0] se_enab;
   logic             se_summary;
   logic             lock_q;
   logic             lock_rise;
   logic [7:0]       sre_q;
   logic [7:0]       stb_d;
   logic             rqs;
   sra_srq_state_t   srq_q;
   logic [7:0]       stb_sum;
   logic             ref_external;
   logic             ext_locked;
   logic [REG_W-1:0] op_rise;
   logic             op_event_rd;
   logic             qu_event_rd;
   logic             se_event_rd;
   logic             op_enab_wr;
   logic             qu_enab_wr;
   logic             se_enab_wr;
   logic             sre_wr;
   logic [REG_W-1:0] rdata_d;

   // Each strobe is decoded once for the groups; the read mux decodes reg_sel on its own with the same codes.
   always_comb begin
      op_event_rd = reg_rd && (reg_sel == SEL_OP_EVENT);
      qu_event_rd = reg_rd && (reg_sel == SEL_QU_EVENT);
      se_event_rd = reg_rd && (reg_sel == SEL_SE_EVENT);
      op_enab_wr  = reg_wr && (reg_sel == SEL_OP_ENAB);
      qu_enab_wr  = reg_wr && (reg_sel == SEL_QU_ENAB);
      se_enab_wr  = reg_wr && (reg_sel == SEL_SE_ENAB);
      sre_wr      = reg_wr && (reg_sel == SEL_SRE);
   end

   // Operation conditions come straight from the live status.
   always_comb begin
      op_cond_in                = '0;
      op_cond_in[OP_CAL_BIT]    = calibrating;
      op_cond_in[OP_MEAS_BIT]   = measuring;
      op_cond_in[OP_INTREF_BIT] = (ref_source == REF_INTERNAL);
   end

   // Only the two external sources can lock; with the internal one selected the lock input is ignored.
   assign ref_external = (ref_source == REF_FRONT) || (ref_source == REF_BACKPLANE);
   assign ext_locked   = ref_locked && ref_external;

   // Lock is an edge: only the transition into phase lock of an external source is an event.
   // Swapping between the two external sources while locked is not a new lock and sets nothing.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         lock_q <= 1'h0;
      end else begin
         lock_q <= ext_locked;
      end
   end
   assign lock_rise = ext_locked && !lock_q;

   // Questionable sources are pulses; a level held high sets the event again every cycle.
   always_comb begin
      qu_set                = '0;
      qu_set[QU_LOCK_BIT]   = lock_rise;
      qu_set[QU_CALERR_BIT] = cal_failed;
      qu_set[QU_MISS_BIT]   = rate_over_limit;
      qu_set[QU_START_BIT]  = start_index_over;
      qu_set[QU_SIZE_BIT]   = size_over;
      qu_set[QU_WARN_BIT]   = param_ignored;
   end

   // Bits 1 and 6 of the standard events have no source, so they stay zero.
   always_comb begin
      se_set             = '0;
      se_set[SE_OPC_BIT] = op_complete;
      se_set[SE_QYE_BIT] = query_error;
      se_set[SE_DDE_BIT] = device_error;
      se_set[SE_EXE_BIT] = exec_error;
      se_set[SE_CME_BIT] = cmd_error;
      se_set[SE_PON_BIT] = power_on;
   end

   // Operation events mark a condition going true; a condition that falls leaves its event alone.
   assign op_rise = op_cond_in & ~op_cond;

   sra_event_group #(
      .W         (REG_W),
      .USED_MASK (OP_USED_MASK)
   ) u_oper (
      .clk          (clk),
      .rstn         (rstn),
      .cond_in      (op_cond_in),
      .event_set    (op_rise),
      .event_read   (op_event_rd),
      .clear_all    (clear_status),
      .enable_we    (op_enab_wr),
      .enable_wdata (reg_wdata),
      .cond_out     (op_cond),
      .event_q      (op_event),
      .enable_q     (op_enab),
      .summary      (op_summary)
   );

   // The questionable mask excludes bit 15, so it always reads zero.
   sra_event_group #(
      .W         (REG_W),
      .USED_MASK (QU_USED_MASK)
   ) u_ques (
      .clk          (clk),
      .rstn         (rstn),
      .cond_in      (qu_set),
      .event_set    (qu_set),
      .event_read   (qu_event_rd),
      .clear_all    (clear_status),
      .enable_we    (qu_enab_wr),
      .enable_wdata (reg_wdata),
      .cond_out     (qu_cond),
      .event_q      (qu_event),
      .enable_q     (qu_enab),
      .summary      (qu_summary)
   );

   // Standard events have no condition register, so that output is left open.
   sra_event_group #(
      .W         (ESR_W),
      .USED_MASK (SE_USED_MASK)
   ) u_std (
      .clk          (clk),
      .rstn         (rstn),
      .cond_in      (se_set),
      .event_set    (se_set),
      .event_read   (se_event_rd),
      .clear_all    (clear_status),
      .enable_we    (se_enab_wr),
      .enable_wdata (reg_wdata[ESR_W-1:0]),
      .cond_out     (),
      .event_q      (se_event),
      .enable_q     (se_enab),
      .summary      (se_summary)
   );

   // Request enable; bit 6 is the request bit itself and cannot be enabled.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sre_q <= '0;
      end else if (sre_wr) begin
         sre_q <= reg_wdata[7:0] & SRE_USED_MASK;
      end
   end

   // Summaries without the request bit, so the request bit can never feed itself.
   always_comb begin
      stb_sum              = '0;
      stb_sum[SB_QUES_BIT] = qu_summary;
      stb_sum[SB_MAV_BIT]  = output_available;
      stb_sum[SB_ESB_BIT]  = se_summary;
      stb_sum[SB_OPER_BIT] = op_summary;
   end
   assign rqs = |(stb_sum & sre_q);

   always_comb begin
      stb_d             = stb_sum;
      stb_d[SB_RQS_BIT] = rqs;
   end

   // The byte and the line are registered from the same summaries, so a poll always agrees with the line.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         status_byte <= '0;
      end else begin
         status_byte <= stb_d;
      end
   end

   // The line follows the enabled summaries; the host clears causes to release it.
   // A poll does not acknowledge it: the line stays up until every enabled cause is gone.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         srq_q <= SRA_SRQ_IDLE;
      end else begin
         case (srq_q)
            SRA_SRQ_IDLE: begin
               if (rqs) begin
                  srq_q <= SRA_SRQ_ASSERT;
               end
            end
            SRA_SRQ_ASSERT: begin
               if (!rqs) begin
                  srq_q <= SRA_SRQ_IDLE;
               end
            end
            default: begin
               srq_q <= SRA_SRQ_IDLE;
            end
         endcase
      end
   end
   assign srq = (srq_q == SRA_SRQ_ASSERT);

   // Clearing status also empties the error queue outside this block.
   // The pulse comes one cycle after the request, in step with the event registers being emptied.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         error_queue_clear <= 1'h0;
      end else begin
         error_queue_clear <= clear_status;
      end
   end

   // Read data is chosen here; condition reads have no side effect.
   // The 8-bit registers sit in the low byte and the high byte reads zero.
   always_comb begin
      rdata_d = '0;
      case (reg_sel)
         SEL_OP_COND:  rdata_d = op_cond;
         SEL_OP_EVENT: rdata_d = op_event;
         SEL_OP_ENAB:  rdata_d = op_enab;
         SEL_QU_COND:  rdata_d = qu_cond;
         SEL_QU_EVENT: rdata_d = qu_event;
         SEL_QU_ENAB:  rdata_d = qu_enab;
         SEL_SE_EVENT: rdata_d = {8'h00, se_event};
         SEL_SE_ENAB:  rdata_d = {8'h00, se_enab};
         SEL_SRE:      rdata_d = {8'h00, sre_q};
         SEL_STB:      rdata_d = {8'h00, status_byte};
         default:      rdata_d = '0;
      endcase
   end

   // The read data holds until the next read, so the host may take it late.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end
endmodule
